// *** core/pwm_led_defines.svh ***
// register indices, field positions and reset values of the led pulse-width modulator
`ifndef PWM_LED_DEFINES_SVH
`define PWM_LED_DEFINES_SVH

// register indices; byte address is four times the index
`define IDX_CTRL        14'h3400
`define IDX_DIVIDER     14'h3402
`define IDX_SLOPE       14'h340a
`define IDX_MAX_DUTY    14'h340c
`define IDX_WHITE       14'h340e
`define IDX_RED_TIMES   14'h3420
`define IDX_GREEN_TIMES 14'h3421
`define IDX_BLUE_TIMES  14'h3422
`define IDX_STATUS      14'h3423

// reset values
`define RST_REG16       16'h0000

// control register fields
`define CTRL_GATE_EN    0
`define CTRL_WHITE_EN   8
`define CTRL_RED_EN     9
`define CTRL_BLUE_EN    11
`define CTRL_EN_HI      11
`define CTRL_EN_LO      8

// field ranges
`define DIV_HI          3
`define SLOPE_HI        7
`define MAXD_HI         4
`define ON_HI           6
`define OFF_HI          14
`define OFF_LO          8
`define WDUTY_HI        5
`define WPER_HI         13
`define WPER_LO         8

// timing figures
`define PWM_STEPS       5'h10
`define PHASE_LAST      4'hf
`define PRESCALE_LSBS   2'h3

`endif

// *** core/pwm_led_pkg.sv ***
// types shared by the led pulse-width modulator files
package pwm_led_pkg;

  typedef struct packed {
    logic [4:0] level;
    logic [7:0] slope_cnt;
  } ramp_state_t;

  typedef struct packed {
    logic [15:0]       ctrl;
    logic [15:0]       divider;
    logic [15:0]       slope;
    logic [15:0]       max_duty;
    logic [15:0]       white;
    logic [2:0][15:0]  times;
    logic              wr_pend;
    logic [13:0]       wr_idx;
    logic              rd_pend;
    logic [13:0]       rd_idx;
    logic [31:0]       hrdata;
    logic              hreadyout;
    logic              hresp;
    logic              src_prev;
    logic              gate_s;
    logic [3:0]        div_cnt;
    logic [3:0]        phase;
    logic [6:0]        period;
    logic [7:0]        w_pre;
    logic [5:0]        w_step;
    logic [3:0]        leds;
  } main_state_t;

endpackage : pwm_led_pkg

// *** core/color_ramp_channel.sv ***
// one colour channel: on/off window inside the shared period and duty ramping
`timescale 1ns/1ps
`include "pwm_led_defines.svh"

module color_ramp_channel (
  // clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // control
  input  wire logic       clear,
  input  wire logic       enable,
  input  wire logic       pulse_tick,
  input  wire logic [6:0] period_count,
  input  wire logic [6:0] on_time,
  input  wire logic [6:0] off_time,
  input  wire logic [7:0] slope,
  input  wire logic [4:0] max_duty,
  // duty level in pwm steps
  output logic      [4:0] level
);

  pwm_led_pkg::ramp_state_t s;
  pwm_led_pkg::ramp_state_t next_s;
  logic [4:0] maxd;
  logic       active;

  // an off time below the on time wraps through the end of the period
  function automatic logic in_window(input logic [6:0] p, input logic [6:0] on_t,
                                     input logic [6:0] off_t);
    if (on_t <= off_t) begin
      in_window = (p >= on_t) && (p < off_t);
    end else begin
      in_window = (p >= on_t) || (p < off_t);
    end
  endfunction : in_window

  always_comb begin
    maxd   = (max_duty > `PWM_STEPS) ? `PWM_STEPS : max_duty;
    active = in_window(period_count, on_time, off_time);
    next_s = s;
    if (clear || !enable) begin
      next_s = '0;
    end else if (pulse_tick) begin
      if (slope == 8'h00) begin
        next_s.level     = active ? maxd : 5'h00;
        next_s.slope_cnt = 8'h00;
      end else if (active) begin
        if (s.level >= maxd) begin
          next_s.level     = maxd;
          next_s.slope_cnt = 8'h00;
        end else if (s.slope_cnt + 8'h01 >= slope) begin
          next_s.level     = s.level + 5'h01;
          next_s.slope_cnt = 8'h00;
        end else begin
          next_s.slope_cnt = s.slope_cnt + 8'h01;
        end
      end else begin
        // ramp stops where it stands and turns down at once
        if (s.level == 5'h00) begin
          next_s.slope_cnt = 8'h00;
        end else if (s.slope_cnt + 8'h01 >= slope) begin
          next_s.level     = s.level - 5'h01;
          next_s.slope_cnt = 8'h00;
        end else begin
          next_s.slope_cnt = s.slope_cnt + 8'h01;
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign level = s.level;

endmodule : color_ramp_channel

// *** core/led_pwm_rgbw_driver.sv ***
// four-channel led pulse-width modulator with an ahb-lite register slave
//
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "pwm_led_defines.svh"

module led_pwm_rgbw_driver (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // pins
  input  wire logic        pwm_source_clock,
  input  wire logic        external_output_gate_input,
  // led outputs
  output logic             led_red,
  output logic             led_green,
  output logic             led_blue,
  output logic             led_white
);

  pwm_led_pkg::main_state_t s;
  pwm_led_pkg::main_state_t next_s;

  logic        src_edge;
  logic        any_en;
  logic        rgb_en;
  logic        pwm_tick;
  logic        pulse_tick;
  logic        gate_ok;
  logic [7:0]  w_limit;
  logic [4:0]  levels [3];
  logic [3:0]  chan;
  logic        addr_ok;

  // read view of the register map; unmapped words read as zero
  function automatic logic [15:0] read_word(input pwm_led_pkg::main_state_t st,
                                            input logic [13:0] idx);
    if (idx == `IDX_CTRL) begin
      read_word = st.ctrl;
    end else if (idx == `IDX_DIVIDER) begin
      read_word = st.divider;
    end else if (idx == `IDX_SLOPE) begin
      read_word = st.slope;
    end else if (idx == `IDX_MAX_DUTY) begin
      read_word = st.max_duty;
    end else if (idx == `IDX_WHITE) begin
      read_word = st.white;
    end else if (idx == `IDX_RED_TIMES) begin
      read_word = st.times[0];
    end else if (idx == `IDX_GREEN_TIMES) begin
      read_word = st.times[1];
    end else if (idx == `IDX_BLUE_TIMES) begin
      read_word = st.times[2];
    end else if (idx == `IDX_STATUS) begin
      read_word = {4'h0, st.leds, rgb_en, st.period};
    end else begin
      read_word = 16'h0000;
    end
  endfunction : read_word

  // colour channels share the period counter and pulse tick
  generate
    for (genvar i = 0; i < 3; i++) begin : g_color
      color_ramp_channel u_chan (
        .hclk         (hclk),
        .hresetn      (hresetn),
        .clear        (!rgb_en),
        .enable       (s.ctrl[`CTRL_RED_EN + i]),
        .pulse_tick   (pulse_tick),
        .period_count (s.period),
        .on_time      (s.times[i][`ON_HI:0]),
        .off_time     (s.times[i][`OFF_HI:`OFF_LO]),
        .slope        (s.slope[`SLOPE_HI:0]),
        .max_duty     (s.max_duty[`MAXD_HI:0]),
        .level        (levels[i])
      );
      // high for the first level steps of each 16-step cycle
      assign chan[i] = ({1'b0, s.phase} < levels[i]);
    end
  endgenerate

  // white: fixed duty out of 64 steps, or off
  assign chan[3] = s.ctrl[`CTRL_WHITE_EN] &&
                   (s.w_step < s.white[`WDUTY_HI:0]);

  always_comb begin
    // the source clock is slow against hclk, so its rising edge becomes a one-cycle tick
    src_edge   = pwm_source_clock && !s.src_prev;
    any_en     = |s.ctrl[`CTRL_EN_HI:`CTRL_EN_LO];
    rgb_en     = |s.ctrl[`CTRL_BLUE_EN:`CTRL_RED_EN];
    // gating by enables stands in for stopping the modulator clock
    pwm_tick   = src_edge && any_en && rgb_en &&
                 (s.div_cnt == s.divider[`DIV_HI:0]);
    pulse_tick = pwm_tick && (s.phase == `PHASE_LAST);
    // white prescale 4*(p+1) source clocks per step: 64 steps give 64 Hz to 1 Hz
    w_limit    = {s.white[`WPER_HI:`WPER_LO], `PRESCALE_LSBS};
    gate_ok    = !s.ctrl[`CTRL_GATE_EN] || s.gate_s;
    addr_ok    = hsel && hready && htrans[1];

    next_s           = s;
    next_s.src_prev  = pwm_source_clock;
    next_s.gate_s    = external_output_gate_input;
    next_s.hresp     = 1'b0;
    next_s.hreadyout = 1'b1;

    // write data phase: whole word taken, upper half ignored
    if (s.wr_pend) begin
      next_s.wr_pend = 1'b0;
      if (s.wr_idx == `IDX_CTRL) begin
        next_s.ctrl = hwdata[15:0];
      end else if (s.wr_idx == `IDX_DIVIDER) begin
        next_s.divider = hwdata[15:0];
      end else if (s.wr_idx == `IDX_SLOPE) begin
        next_s.slope = hwdata[15:0];
      end else if (s.wr_idx == `IDX_MAX_DUTY) begin
        next_s.max_duty = hwdata[15:0];
      end else if (s.wr_idx == `IDX_WHITE) begin
        next_s.white = hwdata[15:0];
      end else if (s.wr_idx == `IDX_RED_TIMES) begin
        next_s.times[0] = hwdata[15:0];
      end else if (s.wr_idx == `IDX_GREEN_TIMES) begin
        next_s.times[1] = hwdata[15:0];
      end else if (s.wr_idx == `IDX_BLUE_TIMES) begin
        next_s.times[2] = hwdata[15:0];
      end
    end

    // one wait state on reads lets a write just before land first
    if (s.rd_pend) begin
      next_s.rd_pend = 1'b0;
      next_s.hrdata  = {16'h0000, read_word(s, s.rd_idx)};
    end

    if (addr_ok) begin
      if (hwrite) begin
        next_s.wr_pend = 1'b1;
        next_s.wr_idx  = haddr[15:2];
      end else begin
        next_s.rd_pend   = 1'b1;
        next_s.rd_idx    = haddr[15:2];
        next_s.hreadyout = 1'b0;
      end
    end

    // colour timing chain
    if (!rgb_en) begin
      next_s.div_cnt = 4'h0;
      next_s.phase   = 4'h0;
      next_s.period  = 7'h00;
    end else if (src_edge && any_en) begin
      if (pwm_tick) begin
        next_s.div_cnt = 4'h0;
        next_s.phase   = s.phase + 4'h1;
        if (pulse_tick) begin
          next_s.period = s.period + 7'h01;
        end
      end else if (s.div_cnt >= s.divider[`DIV_HI:0]) begin
        // divider lowered mid-count; restart rather than run through 16
        next_s.div_cnt = 4'h0;
      end else begin
        next_s.div_cnt = s.div_cnt + 4'h1;
      end
    end

    // white timing, straight from the source clock
    if (!s.ctrl[`CTRL_WHITE_EN]) begin
      next_s.w_pre  = 8'h00;
      next_s.w_step = 6'h00;
    end else if (src_edge) begin
      if (s.w_pre >= w_limit) begin
        next_s.w_pre  = 8'h00;
        next_s.w_step = s.w_step + 6'h01;
      end else begin
        next_s.w_pre = s.w_pre + 8'h01;
      end
    end

    // output stage after the modulators
    next_s.leds = chan & {4{gate_ok}};
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s           <= '0;
      s.ctrl      <= `RST_REG16;
      s.divider   <= `RST_REG16;
      s.slope     <= `RST_REG16;
      s.max_duty  <= `RST_REG16;
      s.white     <= `RST_REG16;
      s.hreadyout <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign hrdata    = s.hrdata;
  assign hreadyout = s.hreadyout;
  assign hresp     = s.hresp;
  assign led_red   = s.leds[0];
  assign led_green = s.leds[1];
  assign led_blue  = s.leds[2];
  assign led_white = s.leds[3];

endmodule : led_pwm_rgbw_driver

// *** verification/led_pwm_checker.sv ***
// concurrent checks on the led modulator ports
`timescale 1ns/1ps
module led_pwm_checker (
  // clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // ahb-lite slave
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // pins
  input wire logic        external_output_gate_input,
  input wire logic        led_red,
  input wire logic        led_green,
  input wire logic        led_blue,
  input wire logic        led_white
);
  logic        take;
  logic        rd_take;
  logic        pend;
  logic [15:0] ctrl;
  logic [3:0]  leds;
  assign take = hsel && hready && htrans[1];
  assign rd_take = take && !hwrite;
  assign leds = {led_white, led_blue, led_green, led_red};
  // shadow of the control register, updated at the same edge as the slave's copy
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend <= 1'b0;
      ctrl <= 16'h0000;
    end else begin
      pend <= take && hwrite && (haddr[15:2] == 14'h3400);
      if (pend) begin
        ctrl <= hwdata[15:0];
      end
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  chk_write_nowait: assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
  chk_wait_cause: assert property ($fell(hreadyout) |-> $past(rd_take))
    else $error("wait state without read");
  chk_rdata_hold: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
    else $error("read data moved between reads");
  chk_gate_force: assert property (
    (ctrl[0] && !external_output_gate_input)[*3] |-> leds == 4'h0)
    else $error("gated outputs lit");
  chk_all_off: assert property ((ctrl[11:8] == 4'h0)[*4] |-> leds == 4'h0)
    else $error("outputs lit with all enables clear");
  chk_rgb_off: assert property ((ctrl[11:9] == 3'h0)[*4] |-> leds[2:0] == 3'h0)
    else $error("colour lit with colours disabled");
  chk_white_off: assert property ((!ctrl[8])[*4] |-> !led_white)
    else $error("white lit while disabled");
  chk_resp_okay: assert property (!hresp)
    else $error("error response seen");
endmodule : led_pwm_checker

// *** verification/led_load_model.sv ***
// led driver model: counts the hclk cycles each output is lit
`timescale 1ns/1ps
module led_load_model (
  // clock and control
  input  wire logic        hclk,
  input  wire logic        clear,
  // led inputs
  input  wire logic        led_red,
  input  wire logic        led_green,
  input  wire logic        led_blue,
  input  wire logic        led_white,
  // lit counts, red at index 0
  output logic [3:0][15:0] lit
);
  logic [3:0] leds;
  assign leds = {led_white, led_blue, led_green, led_red};
  always_ff @(posedge hclk) begin
    for (int i = 0; i < 4; i++) begin
      lit[i] <= clear ? 16'h0000 : lit[i] + 16'(leds[i]);
    end
  end
endmodule : led_load_model

// *** verification/tb_top.sv ***
// self-checking bench for the led modulator
`timescale 1ns/1ps
module tb_top;
  logic             hclk;
  logic             hresetn;
  logic             hsel;
  logic [31:0]      haddr;
  logic [1:0]       htrans;
  logic             hwrite;
  logic [2:0]       hsize;
  logic [31:0]      hwdata;
  logic [31:0]      hrdata;
  logic             hreadyout;
  logic             src;
  logic             gate_pin;
  logic             clear;
  logic             led_r;
  logic             led_g;
  logic             led_b;
  logic             led_w;
  logic [3:0][15:0] lit;
  logic [31:0]      rd;
  logic [31:0]      wd;
  int               n_fail;
  int               tests_run;
  int               p;
  int               d;
  int               v;
  int               m;
  localparam logic [31:0] REGS [8] = '{32'hd000, 32'hd008, 32'hd028, 32'hd030,
                                       32'hd038, 32'hd080, 32'hd084, 32'hd088};
  led_pwm_rgbw_driver i_led_pwm_rgbw_driver (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(),
    .pwm_source_clock(src), .external_output_gate_input(gate_pin),
    .led_red(led_r), .led_green(led_g), .led_blue(led_b), .led_white(led_w));
  led_load_model i_led_load_model (.hclk(hclk), .clear(clear), .led_red(led_r),
    .led_green(led_g), .led_blue(led_b), .led_white(led_w), .lit(lit));
  always #5 hclk = ~hclk;
  // slow source: one rising edge every four hclk
  always begin
    repeat (2) @(posedge hclk);
    src <= ~src;
  end
  function automatic logic [31:0] white_lit(input int p, input int d);
    return 32'(16 * (p + 1) * d);
  endfunction : white_lit
  function automatic logic [31:0] rgb_lit(input int v, input int m);
    return 32'(4 * (v + 1) * (m > 16 ? 16 : m));
  endfunction : rgb_lit
  // lit cycles over one steady 128-step period, one level per sl pulse ticks
  function automatic logic [31:0] ramp_lit(input int on_t, input int off_t, input int sl,
                                           input int mx);
    int lvl;
    int cnt;
    int sum;
    bit up;
    lvl = 0;
    cnt = 0;
    sum = 0;
    for (int t = 0; t < 256; t++) begin
      up = ((t % 128) >= on_t) && ((t % 128) < off_t);
      if (t >= 128) begin
        sum += lvl;
      end
      if (up ? (lvl >= mx) : (lvl == 0)) begin
        cnt = 0;
      end else if (cnt + 1 >= sl) begin
        cnt = 0;
        lvl = up ? lvl + 1 : lvl - 1;
      end else begin
        cnt++;
      end
    end
    return 32'(4 * sum);
  endfunction : ramp_lit
  task automatic check(input logic [31:0] seen, input logic [31:0] expd);
    tests_run++;
    if (seen !== expd) begin
      n_fail++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, expd);
    end
  endtask : check
  task automatic bus(input logic wr, input logic [31:0] addr, input logic [31:0] data);
    hsel <= 1'b1;
    haddr <= addr;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= data;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  // counts over win cycles after a settling wait
  task automatic measure(input int wait_n, input int win);
    repeat (wait_n) @(posedge hclk);
    clear <= 1'b1;
    @(posedge hclk);
    clear <= 1'b0;
    repeat (win) @(posedge hclk);
    #1;
  endtask : measure
  task automatic end_sim();
    if (n_fail == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim
  initial begin
    #500_000;
    n_fail++;
    end_sim();
  end
  initial begin
    {hclk, hresetn, hsel, haddr, htrans, hwrite, hsize, hwdata, src, clear} = '0;
    {gate_pin, n_fail, tests_run} = '0;
    gate_pin = 1'b1;
    void'($urandom(83635));
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    foreach (REGS[i]) begin
      bus(1'b0, REGS[i], 32'h0);
      check(rd, 32'h0);
      wd = $urandom();
      bus(1'b1, REGS[i], wd);
      bus(1'b0, REGS[i], 32'h0);
      check(rd, {16'h0000, wd[15:0]});
    end
    bus(1'b1, 32'hd004, 32'hffffffff);
    bus(1'b0, 32'hd004, 32'h0);
    check(rd, 32'h0);
    bus(1'b1, 32'hd000, 32'h0);
    for (int i = 0; i < 3; i++) begin
      p = (i == 2) ? 1 : 0;
      d = (i == 0) ? 63 : (i == 1) ? 0 : 1 + $urandom_range(61);
      bus(1'b1, 32'hd038, 32'((p << 8) | d));
      bus(1'b1, 32'hd000, 32'h0100);
      measure(1100 * (p + 1), 1024 * (p + 1));
      check({16'h0, lit[3]}, white_lit(p, d));
    end
    bus(1'b1, 32'hd080, 32'h7f00);
    bus(1'b1, 32'hd084, 32'h7f00);
    bus(1'b1, 32'hd088, 32'h7f40);
    // cases: plain step, divide by sixteen, ramp with a clamped maximum
    for (int i = 0; i < 3; i++) begin
      v = (i == 1) ? 15 : 0;
      m = (i == 0) ? 16 : (i == 1) ? 1 + $urandom_range(14) : 20;
      bus(1'b1, 32'hd000, 32'h0);
      bus(1'b1, 32'hd008, 32'(v));
      bus(1'b1, 32'hd028, 32'(i == 2));
      bus(1'b1, 32'hd030, 32'(m));
      bus(1'b1, 32'hd000, 32'h0e00);
      measure(3000, 64 * (v + 1));
      check({16'h0, lit[0]}, rgb_lit(v, m));
      check({16'h0, lit[1]}, rgb_lit(v, m));
      check({16'h0, lit[2]}, 32'h0);
      if (i == 0) begin
        measure(3000, 64);
        check({16'h0, lit[2]}, rgb_lit(v, m));
      end
    end
    bus(1'b1, 32'hd000, 32'h0e01);
    gate_pin <= 1'b0;
    measure(10, 64);
    check({16'h0, lit[0]}, 32'h0);
    gate_pin <= 1'b1;
    measure(10, 64);
    check({16'h0, lit[0]}, rgb_lit(0, m));
    // red window too short for the ramp to reach its maximum
    bus(1'b1, 32'hd000, 32'h0);
    bus(1'b1, 32'hd080, 32'h0400);
    bus(1'b1, 32'hd028, 32'h2);
    bus(1'b1, 32'hd000, 32'h0e00);
    measure(8300, 8192);
    check({16'h0, lit[0]}, ramp_lit(0, 4, 2, m > 16 ? 16 : m));
    check({16'h0, lit[1]}, ramp_lit(0, 127, 2, m > 16 ? 16 : m));
    check({16'h0, lit[2]}, ramp_lit(64, 127, 2, m > 16 ? 16 : m));
    bus(1'b1, 32'hd000, 32'h0);
    measure(10, 64);
    check({16'h0, lit[0] | lit[1] | lit[2] | lit[3]}, 32'h0);
    bus(1'b0, 32'hd08c, 32'h0);
    check(rd, 32'h0);
    end_sim();
  end
endmodule : tb_top
bind led_pwm_rgbw_driver led_pwm_checker i_led_pwm_checker (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .external_output_gate_input(external_output_gate_input), .led_red(led_red),
  .led_green(led_green), .led_blue(led_blue), .led_white(led_white));
